/* tmbx_map.svh */
// Offsets, field positions, codes and timing for the touch mailbox.
// Included by name; holds definitions only.
`ifndef TMBX_MAP_SVH
`define TMBX_MAP_SVH
`define TMBX_A_SFLAGS 8'h00
`define TMBX_A_MODES 8'h01
`define TMBX_A_CFLAGS 8'h02
`define TMBX_A_STATUS 8'h03
`define TMBX_A_PARAM1 8'h04
`define TMBX_A_PARAM7 8'h0a
`define TMBX_A_COUNT 8'h0b
`define TMBX_A_CSTAT 8'h0c
`define TMBX_A_CALL 8'h0d
`define TMBX_A_PWRCLK 8'h0e
`define TMBX_A_GPM_LO 8'h0f
`define TMBX_A_GPM_HI 8'h10
`define TMBX_A_GPL_LO 8'h11
`define TMBX_A_GPL_HI 8'h12
`define TMBX_BUF_BIT 7
`define TMBX_POS_BASE 7'h00
`define TMBX_CTL_BASE 7'h40
`define TMBX_SF_TOUCH 0
`define TMBX_SF_POINTER 1
`define TMBX_SF_STYLUS 2
`define TMBX_SF_RX 3
`define TMBX_SF_SUSP 4
`define TMBX_CF_WRITTEN 0
`define TMBX_CF_REQ 1
`define TMBX_CF_REPLY 2
`define TMBX_CS_RUN 7
`define TMBX_CS_OVF 0
`define TMBX_RES_OK 8'h00
`define TMBX_RES_RANGE 8'h01
`define TMBX_RES_BUSY 8'h02
`define TMBX_RES_RX_EMPTY 8'h03
`define TMBX_RES_WAKE_NA 8'h04
`define TMBX_CALL_SYS_INIT 8'h01
`define TMBX_CALL_USB_INIT 8'h02
`define TMBX_CALL_GPIO_INIT 8'h03
`define TMBX_CALL_SUSPEND 8'h04
`define TMBX_CALL_SUSP_WAKE 8'h05
`define TMBX_CALL_REM_WAKE 8'h06
`define TMBX_CALL_RX_DEQ 8'h07
`define TMBX_CALL_CNT_START 8'h08
`define TMBX_CALL_CNT_STOP 8'h09
`define TMBX_REG_BUS_POW 8'h00
`define TMBX_REG_SELF_OFF 8'h01
`define TMBX_REG_SELF_ON 8'h02
`define TMBX_CLK_FAST 8'h00
`define TMBX_CLK_HALF 8'h01
`define TMBX_RST_BYTE 8'h00
`define TMBX_TICK_US 500
`define TMBX_CLK_MHZ 10
`define TMBX_TICK_CYCLES (`TMBX_TICK_US * `TMBX_CLK_MHZ)
`define TMBX_REPORT_LEN 16
`define TMBX_RX_DEPTH 8
`endif

/* tmbx_pkg.sv */
// Types shared by the touch mailbox modules.
// Assumes nothing of its surroundings.
package tmbx_pkg;
  typedef enum logic [1:0] {ENG_IDLE, ENG_FETCH, ENG_LOAD, ENG_SEND} tmbx_eng_e;
  typedef enum logic [1:0] {SRC_TOUCH, SRC_POINTER, SRC_STYLUS, SRC_CTRL} tmbx_src_e;
  typedef logic [7:0] tmbx_byte_t;
endpackage

/* tmbx_ram_if.sv */
// Two-port link between the mailbox and its buffer memory.
// Assumes one clock shared by both ends.
`timescale 1ns/10ps
`default_nettype none
interface tmbx_ram_if;
  logic [6:0] a_addr;
  logic [7:0] a_wdata;
  logic a_we;
  logic [7:0] a_rdata;
  logic [6:0] b_addr;
  logic [7:0] b_wdata;
  logic b_we;
  logic [7:0] b_rdata;
  modport mem (input a_addr, a_wdata, a_we, b_addr, b_wdata, b_we, output a_rdata, b_rdata);
  modport user (output a_addr, a_wdata, a_we, b_addr, b_wdata, b_we, input a_rdata, b_rdata);
endinterface
`default_nettype wire

/* tmbx_buf_mem.sv */
// Position and control buffers, 128 bytes, two ports.
// Assumes the same clock on both ports; read data are registered.
`timescale 1ns/10ps
`default_nettype none
module tmbx_buf_mem (
  input wire logic i_sys_clk,
  tmbx_ram_if.mem bus
);
  logic [7:0] ram_ff [128];

  // Port b wins a same-address write collision
  always_ff @(posedge i_sys_clk) begin
    if (bus.a_we) begin
      ram_ff[bus.a_addr] <= bus.a_wdata;
    end
    if (bus.b_we) begin
      ram_ff[bus.b_addr] <= bus.b_wdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    bus.a_rdata <= ram_ff[bus.a_addr];
    bus.b_rdata <= ram_ff[bus.b_addr];
  end
endmodule
`default_nettype wire

/* tmbx_mailbox.sv */
// Shared flag and variable mailbox of the touch bridge, with buffers,
// report copy engine, serial receive queue, service calls and tick counter.
// Assumes one clock; USB core logic and serial receiver share it.
`timescale 1ns/10ps
`default_nettype none
`include "tmbx_map.svh"
// Function
// - Device clears pending flag after FIFO copy
// - Pointer and stylus flags share touch handshake
// - Receive flag stays set while bytes remain
// - Host suspend sets suspend request flag
// - Leaving suspend clears suspend request flag
// - Host data sets control written flag
// - Host request sets control requested flag
// - Reply ready flag cleared after FIFO copy
// - Every service call writes a result code
// - Running counter increments every 500 us
// - Counter status top bit is run
// - Wrap sets overflow bit; software may clear
// - Three regulator and power settings offered
// - Core clock 48 or 24 MHz
// - USB initialisation starts the tick counter
// - Sixteen GPIO mode bits and latches
// - Full suspend stalls; transceiver suspend returns
// - Remote wake only from transceiver suspend
module tmbx_mailbox #(
  parameter int TICK_CYCLES = `TMBX_TICK_CYCLES,
  parameter int REPORT_LEN = `TMBX_REPORT_LEN,
  parameter int RX_DEPTH = `TMBX_RX_DEPTH
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_mode_wr,
  input wire logic [7:0] i_mode_data,
  input wire logic i_host_wr,
  input wire logic [5:0] i_host_addr,
  input wire logic [7:0] i_host_data,
  input wire logic i_host_done,
  input wire logic i_ctrl_req,
  output logic o_fifo_valid,
  output logic [7:0] o_fifo_data,
  output logic [1:0] o_fifo_kind,
  output logic o_fifo_last,
  input wire logic i_fifo_ready,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  output logic o_rx_ready,
  input wire logic i_usb_suspend,
  output logic o_vreg_on,
  output logic o_bus_current_req,
  output logic o_core_clk_half,
  output logic [15:0] o_gpio_pp,
  output logic [15:0] o_gpio_latch,
  output logic o_usb_enabled,
  output logic o_xcvr_suspend,
  output logic o_low_power,
  output logic o_remote_wake
);
  localparam int PW = $clog2(RX_DEPTH);

  if (TICK_CYCLES < 2 || TICK_CYCLES > 65536) begin : g_chk_tick
    $error("TICK_CYCLES out of range");
  end
  if (REPORT_LEN < 1 || REPORT_LEN > 64) begin : g_chk_len
    $error("REPORT_LEN must be 1 to 64");
  end
  if (RX_DEPTH < 2 || (1 << PW) != RX_DEPTH) begin : g_chk_rx
    $error("RX_DEPTH must be a power of two");
  end

  tmbx_ram_if mem_bus ();
  tmbx_buf_mem u_mem (
    .i_sys_clk(i_sys_clk),
    .bus(mem_bus.mem)
  );

  logic touch_ff, pointer_ff, stylus_ff, rx_avail_ff, susp_ff;
  logic [7:0] modes_ff, status_ff, count_ff;
  logic written_ff, req_ff, reply_ff, run_ff, ovf_ff, rd_mem_ff;
  logic [7:0] params_ff [7];
  logic [7:0] rd_reg_ff, rd_val, call_code;
  logic [15:0] presc_ff;
  logic [1:0] reg_sel_ff;
  tmbx_pkg::tmbx_eng_e eng_ff;
  tmbx_pkg::tmbx_src_e src_ff;
  logic [5:0] idx_ff;
  logic [6:0] base_ff;
  logic s1_ff, s2_ff, s3_ff, sus_lvl_ff;
  logic [7:0] rxq_ff [RX_DEPTH];
  logic [PW-1:0] wp_ff, rp_ff;
  logic [PW:0] rxcnt_ff, nxt_rxcnt;

  wire reg_wr = i_wr && !i_addr[`TMBX_BUF_BIT];
  wire call = reg_wr && i_addr == `TMBX_A_CALL;
  wire sw_sflags = reg_wr && i_addr == `TMBX_A_SFLAGS;
  wire sw_cflags = reg_wr && i_addr == `TMBX_A_CFLAGS;
  wire sw_cstat = reg_wr && i_addr == `TMBX_A_CSTAT;
  wire sw_count = reg_wr && i_addr == `TMBX_A_COUNT;
  wire tick = run_ff && presc_ff == 16'(TICK_CYCLES - 1);
  wire eng_last = idx_ff == 6'(REPORT_LEN - 1);
  wire eng_done = eng_ff == tmbx_pkg::ENG_SEND && o_fifo_valid && i_fifo_ready && eng_last;
  wire sus_rise = s2_ff == s3_ff && s2_ff && !sus_lvl_ff;
  wire sus_fall = s2_ff == s3_ff && !s2_ff && sus_lvl_ff;
  wire rx_push = i_rx_valid && o_rx_ready;
  wire rx_pop = call && i_wdata == `TMBX_CALL_RX_DEQ && rxcnt_ff != '0;

  // Software port a: buffer writes and reads
  assign mem_bus.a_addr = i_addr[6:0];
  assign mem_bus.a_wdata = i_wdata;
  assign mem_bus.a_we = i_wr && i_addr[`TMBX_BUF_BIT];
  // Host control writes take port b; the engine waits in ENG_FETCH while they last
  assign mem_bus.b_addr = i_host_wr ? `TMBX_CTL_BASE + {1'b0, i_host_addr}
                                    : base_ff + {1'b0, idx_ff};
  assign mem_bus.b_wdata = i_host_data;
  assign mem_bus.b_we = i_host_wr;

  // Level of the suspend pin, three stages, filtered
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      sus_lvl_ff <= 1'b0;
    end else begin
      s1_ff <= i_usb_suspend;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        sus_lvl_ff <= s2_ff;
      end
    end
  end

  // Report pending flags; a software set wins over the engine clear
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      touch_ff <= 1'b0;
      pointer_ff <= 1'b0;
      stylus_ff <= 1'b0;
    end else begin
      if (sw_sflags && i_wdata[`TMBX_SF_TOUCH]) begin
        touch_ff <= 1'b1;
      end else if (eng_done && src_ff == tmbx_pkg::SRC_TOUCH) begin
        touch_ff <= 1'b0;
      end
      if (sw_sflags && i_wdata[`TMBX_SF_POINTER]) begin
        pointer_ff <= 1'b1;
      end else if (eng_done && src_ff == tmbx_pkg::SRC_POINTER) begin
        pointer_ff <= 1'b0;
      end
      if (sw_sflags && i_wdata[`TMBX_SF_STYLUS]) begin
        stylus_ff <= 1'b1;
      end else if (eng_done && src_ff == tmbx_pkg::SRC_STYLUS) begin
        stylus_ff <= 1'b0;
      end
    end
  end

  a_touch_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    eng_done && src_ff == tmbx_pkg::SRC_TOUCH && !sw_sflags |=> !touch_ff)
    else $error("touch flag not cleared after copy");
  a_kind_pending: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    o_fifo_valid && o_fifo_kind == 2'h2 |-> stylus_ff)
    else $error("stylus byte sent without pending flag");

  // Suspend request follows the filtered bus state
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      susp_ff <= 1'b0;
    end else if (sus_rise) begin
      susp_ff <= 1'b1;
    end else if (sus_fall) begin
      susp_ff <= 1'b0;
    end
  end

  a_susp_set: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    sus_rise |=> susp_ff)
    else $error("suspend flag not set");
  a_susp_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    sus_fall |=> !susp_ff && !o_low_power && !o_xcvr_suspend)
    else $error("suspend state not left on resume");

  // Host mode bits and control flags; sets win over clears
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      modes_ff <= `TMBX_RST_BYTE;
      written_ff <= 1'b0;
      req_ff <= 1'b0;
      reply_ff <= 1'b0;
    end else begin
      if (i_mode_wr) begin
        modes_ff <= i_mode_data;
      end
      if (i_host_done) begin
        written_ff <= 1'b1;
      end else if (sw_cflags && !i_wdata[`TMBX_CF_WRITTEN]) begin
        written_ff <= 1'b0;
      end
      if (i_ctrl_req) begin
        req_ff <= 1'b1;
      end else if (eng_done && src_ff == tmbx_pkg::SRC_CTRL) begin
        req_ff <= 1'b0;
      end
      if (sw_cflags && i_wdata[`TMBX_CF_REPLY]) begin
        reply_ff <= 1'b1;
      end else if (eng_done && src_ff == tmbx_pkg::SRC_CTRL) begin
        reply_ff <= 1'b0;
      end
    end
  end

  a_ctl_written: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    i_host_done |=> written_ff)
    else $error("control written flag not set");
  a_ctl_request: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    i_ctrl_req |=> req_ff)
    else $error("control requested flag not set");

  // Copy engine: one buffered report at a time into the USB FIFO
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      eng_ff <= tmbx_pkg::ENG_IDLE;
      src_ff <= tmbx_pkg::SRC_TOUCH;
      base_ff <= `TMBX_POS_BASE;
      idx_ff <= '0;
      o_fifo_valid <= 1'b0;
      o_fifo_data <= `TMBX_RST_BYTE;
      o_fifo_kind <= 2'h0;
      o_fifo_last <= 1'b0;
    end else begin
      case (eng_ff)
        tmbx_pkg::ENG_IDLE: begin
          idx_ff <= '0;
          base_ff <= `TMBX_POS_BASE;
          if (touch_ff) begin
            src_ff <= tmbx_pkg::SRC_TOUCH;
            eng_ff <= tmbx_pkg::ENG_FETCH;
          end else if (pointer_ff) begin
            src_ff <= tmbx_pkg::SRC_POINTER;
            eng_ff <= tmbx_pkg::ENG_FETCH;
          end else if (stylus_ff) begin
            src_ff <= tmbx_pkg::SRC_STYLUS;
            eng_ff <= tmbx_pkg::ENG_FETCH;
          end else if (reply_ff) begin
            src_ff <= tmbx_pkg::SRC_CTRL;
            base_ff <= `TMBX_CTL_BASE;
            eng_ff <= tmbx_pkg::ENG_FETCH;
          end
        end
        tmbx_pkg::ENG_FETCH: begin
          if (!i_host_wr) begin
            eng_ff <= tmbx_pkg::ENG_LOAD;
          end
        end
        tmbx_pkg::ENG_LOAD: begin
          o_fifo_valid <= 1'b1;
          o_fifo_data <= mem_bus.b_rdata;
          o_fifo_kind <= src_ff;
          o_fifo_last <= eng_last;
          eng_ff <= tmbx_pkg::ENG_SEND;
        end
        default: begin
          if (i_fifo_ready) begin
            o_fifo_valid <= 1'b0;
            o_fifo_last <= 1'b0;
            idx_ff <= idx_ff + 6'h01;
            eng_ff <= eng_last ? tmbx_pkg::ENG_IDLE : tmbx_pkg::ENG_FETCH;
          end
        end
      endcase
    end
  end

  // Serial receive queue; small, so kept in flops
  always_comb begin
    nxt_rxcnt = rxcnt_ff;
    if (rx_push && !rx_pop) begin
      nxt_rxcnt = rxcnt_ff + 1'b1;
    end else if (rx_pop && !rx_push) begin
      nxt_rxcnt = rxcnt_ff - 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (rx_push) begin
      rxq_ff[wp_ff] <= i_rx_data;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      wp_ff <= '0;
      rp_ff <= '0;
      rxcnt_ff <= '0;
      rx_avail_ff <= 1'b0;
      o_rx_ready <= 1'b0;
    end else begin
      wp_ff <= wp_ff + PW'(rx_push);
      rp_ff <= rp_ff + PW'(rx_pop);
      rxcnt_ff <= nxt_rxcnt;
      rx_avail_ff <= nxt_rxcnt != '0;
      o_rx_ready <= nxt_rxcnt < (PW+1)'(RX_DEPTH);
    end
  end

  a_rx_empty: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    rx_pop && rxcnt_ff == 1 && !rx_push |=> !rx_avail_ff)
    else $error("receive flag left set on empty queue");

  // Result of a service call
  always_comb begin
    call_code = `TMBX_RES_RANGE;
    case (i_wdata)
      `TMBX_CALL_SYS_INIT: begin
        if (params_ff[0] <= `TMBX_REG_SELF_ON && params_ff[1] <= `TMBX_CLK_HALF) begin
          call_code = `TMBX_RES_OK;
        end
      end
      `TMBX_CALL_USB_INIT, `TMBX_CALL_GPIO_INIT, `TMBX_CALL_SUSP_WAKE,
      `TMBX_CALL_CNT_START, `TMBX_CALL_CNT_STOP: call_code = `TMBX_RES_OK;
      `TMBX_CALL_SUSPEND: call_code = susp_ff ? `TMBX_RES_BUSY : `TMBX_RES_RANGE;
      `TMBX_CALL_REM_WAKE: begin
        call_code = (susp_ff && o_xcvr_suspend) ? `TMBX_RES_OK : `TMBX_RES_WAKE_NA;
      end
      `TMBX_CALL_RX_DEQ: begin
        call_code = rxcnt_ff != '0 ? `TMBX_RES_OK : `TMBX_RES_RX_EMPTY;
      end
      default: call_code = `TMBX_RES_RANGE;
    endcase
  end

  // Status byte; a full suspend shows busy until the host resumes
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      status_ff <= `TMBX_RES_OK;
    end else if (call) begin
      status_ff <= call_code;
    end else if (sus_fall && o_low_power) begin
      status_ff <= `TMBX_RES_OK;
    end
  end

  a_call_status: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    call |=> status_ff == $past(call_code))
    else $error("status byte not written by call");

  // Call parameters; dequeue returns its byte in the first slot
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      for (int k = 0; k < 7; k++) begin
        params_ff[k] <= `TMBX_RST_BYTE;
      end
    end else if (rx_pop) begin
      params_ff[0] <= rxq_ff[rp_ff];
    end else if (reg_wr && i_addr >= `TMBX_A_PARAM1 && i_addr <= `TMBX_A_PARAM7) begin
      params_ff[3'(i_addr - `TMBX_A_PARAM1)] <= i_wdata;
    end
  end

  // Power, clock and GPIO setup taken from the parameters
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      reg_sel_ff <= 2'h0;
      o_vreg_on <= 1'b1;
      o_bus_current_req <= 1'b1;
      o_core_clk_half <= 1'b0;
      o_gpio_pp <= 16'h0000;
      o_gpio_latch <= 16'hffff;
    end else if (call && call_code == `TMBX_RES_OK) begin
      if (i_wdata == `TMBX_CALL_SYS_INIT) begin
        reg_sel_ff <= params_ff[0][1:0];
        o_vreg_on <= params_ff[0] != `TMBX_REG_SELF_OFF;
        o_bus_current_req <= params_ff[0] == `TMBX_REG_BUS_POW;
        o_core_clk_half <= params_ff[1] == `TMBX_CLK_HALF;
      end
      if (i_wdata == `TMBX_CALL_GPIO_INIT) begin
        o_gpio_pp <= {params_ff[1], params_ff[0]};
        o_gpio_latch <= {params_ff[3], params_ff[2]};
      end
    end
  end

  // USB bring-up and both suspend forms
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_usb_enabled <= 1'b0;
      o_low_power <= 1'b0;
      o_xcvr_suspend <= 1'b0;
      o_remote_wake <= 1'b0;
    end else begin
      o_remote_wake <= 1'b0;
      if (call && i_wdata == `TMBX_CALL_USB_INIT) begin
        o_usb_enabled <= 1'b1;
      end
      if (sus_fall) begin
        o_low_power <= 1'b0;
        o_xcvr_suspend <= 1'b0;
      end else if (call && susp_ff) begin
        if (i_wdata == `TMBX_CALL_SUSPEND) begin
          o_low_power <= 1'b1;
        end
        if (i_wdata == `TMBX_CALL_SUSP_WAKE) begin
          o_xcvr_suspend <= 1'b1;
        end
      end
      if (call && i_wdata == `TMBX_CALL_REM_WAKE && call_code == `TMBX_RES_OK) begin
        o_remote_wake <= 1'b1;
      end
    end
  end

  a_full_susp: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    o_low_power && !sus_fall && !call |=> status_ff == `TMBX_RES_BUSY)
    else $error("full suspend does not hold the call");
  a_wake_refused: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    call && i_wdata == `TMBX_CALL_REM_WAKE && !o_xcvr_suspend
    |=> status_ff == `TMBX_RES_WAKE_NA && !o_remote_wake)
    else $error("remote wake not refused");

  // Tick prescaler and run bit
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      run_ff <= 1'b0;
      presc_ff <= 16'h0000;
    end else begin
      presc_ff <= (tick || !run_ff) ? 16'h0000 : presc_ff + 16'h0001;
      if (call && (i_wdata == `TMBX_CALL_USB_INIT || i_wdata == `TMBX_CALL_CNT_START)) begin
        run_ff <= 1'b1;
      end else if (call && i_wdata == `TMBX_CALL_CNT_STOP) begin
        run_ff <= 1'b0;
      end else if (sw_cstat) begin
        run_ff <= i_wdata[`TMBX_CS_RUN];
      end
    end
  end

  // Counter byte and overflow; a wrap wins over a software clear
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      count_ff <= `TMBX_RST_BYTE;
      ovf_ff <= 1'b0;
    end else begin
      if (sw_count) begin
        count_ff <= i_wdata;
      end else if (tick) begin
        count_ff <= count_ff + 8'h01;
      end
      if (tick && !sw_count && count_ff == 8'hff) begin
        ovf_ff <= 1'b1;
      end else if (sw_cstat && !i_wdata[`TMBX_CS_OVF]) begin
        ovf_ff <= 1'b0;
      end
    end
  end

  a_tick_step: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    tick && !sw_count |=> count_ff == $past(count_ff) + 8'h01 && !tick)
    else $error("counter did not step on tick");
  a_ovf_set: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    tick && !sw_count && count_ff == 8'hff |=> ovf_ff && count_ff == 8'h00)
    else $error("overflow not flagged on wrap");

  // Register read decode
  always_comb begin
    rd_val = 8'h00;
    if (i_addr == `TMBX_A_SFLAGS) begin
      rd_val = {3'h0, susp_ff, rx_avail_ff, stylus_ff, pointer_ff, touch_ff};
    end else if (i_addr == `TMBX_A_MODES) begin
      rd_val = modes_ff;
    end else if (i_addr == `TMBX_A_CFLAGS) begin
      rd_val = {5'h00, reply_ff, req_ff, written_ff};
    end else if (i_addr == `TMBX_A_STATUS) begin
      rd_val = status_ff;
    end else if (i_addr >= `TMBX_A_PARAM1 && i_addr <= `TMBX_A_PARAM7) begin
      rd_val = params_ff[3'(i_addr - `TMBX_A_PARAM1)];
    end else if (i_addr == `TMBX_A_COUNT) begin
      rd_val = count_ff;
    end else if (i_addr == `TMBX_A_CSTAT) begin
      rd_val = {run_ff, 6'h00, ovf_ff};
    end else if (i_addr == `TMBX_A_PWRCLK) begin
      rd_val = {5'h00, o_core_clk_half, reg_sel_ff};
    end else if (i_addr == `TMBX_A_GPM_LO) begin
      rd_val = o_gpio_pp[7:0];
    end else if (i_addr == `TMBX_A_GPM_HI) begin
      rd_val = o_gpio_pp[15:8];
    end else if (i_addr == `TMBX_A_GPL_LO) begin
      rd_val = o_gpio_latch[7:0];
    end else if (i_addr == `TMBX_A_GPL_HI) begin
      rd_val = o_gpio_latch[15:8];
    end
  end

  // Buffer bytes come from the memory's own output register
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      rd_reg_ff <= 8'h00;
      rd_mem_ff <= 1'b0;
    end else begin
      rd_reg_ff <= i_rd ? rd_val : 8'h00;
      rd_mem_ff <= i_rd && i_addr[`TMBX_BUF_BIT];
    end
  end

  assign o_rdata = rd_mem_ff ? mem_bus.a_rdata : rd_reg_ff;
endmodule
`default_nettype wire

/* tmbx_usb_host.sv */
// USB host model: drains report bytes with random stalls.
// Assumes the mailbox clock and its FIFO handshake.
`timescale 1ns/10ps
`default_nettype none
module tmbx_usb_host (
  input wire logic i_clk,
  input wire logic i_valid,
  input wire logic [7:0] i_data,
  input wire logic [1:0] i_kind,
  input wire logic i_last,
  output logic o_ready
);
  logic [10:0] got[$];
  logic [7:0] s = 8'h5b;
  always @(posedge i_clk) begin
    if (i_valid && o_ready) got.push_back({i_last, i_kind, i_data});
    s <= {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    o_ready <= s[0];
  end
endmodule
`default_nettype wire

/* touch_usb_shared_flag_mailbox_tb.sv */
// Bench for the touch mailbox against a queue model of reports.
// Assumes the host model drains the report FIFO.
`timescale 1ns/10ps
`default_nettype none
`include "tmbx_map.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module touch_usb_shared_flag_mailbox_tb;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, mwr = 0, hdone = 0, creq = 0;
  logic rxv = 0, susp = 0, hw = 0, frdy, fv, lw, xs, fl, rxr, vr, bc, ch, ue, rw;
  logic [7:0] addr = 0, wd = 0, rdat, fd, rxd = 0, d, b0, md = 0, hdat = 0;
  logic [5:0] ha = 0;
  logic [15:0] gp, gl;
  logic [1:0] fk;
  logic [31:0] seed = 32'h0fb7bd0d;
  logic [10:0] exp_q[$];
  logic [10:0] got_b, exp_b;
  int mismatches = 0, n_checks = 0, cycles = 0, n_wake = 0;
  tmbx_mailbox #(.TICK_CYCLES(8), .REPORT_LEN(4), .RX_DEPTH(8)) i_dut (
    .i_sys_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wd), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdat), .i_mode_wr(mwr), .i_mode_data(md),
    .i_host_wr(hw), .i_host_addr(ha), .i_host_data(hdat),
    .i_host_done(hdone), .i_ctrl_req(creq), .o_fifo_valid(fv),
    .o_fifo_data(fd), .o_fifo_kind(fk), .o_fifo_last(fl), .i_fifo_ready(frdy),
    .i_rx_valid(rxv), .i_rx_data(rxd), .o_rx_ready(rxr), .i_usb_suspend(susp),
    .o_vreg_on(vr), .o_bus_current_req(bc), .o_core_clk_half(ch), .o_gpio_pp(gp),
    .o_gpio_latch(gl), .o_usb_enabled(ue), .o_xcvr_suspend(xs), .o_low_power(lw),
    .o_remote_wake(rw));
  tmbx_usb_host i_host (.i_clk(clk), .i_valid(fv), .i_data(fd), .i_kind(fk),
    .i_last(fl), .o_ready(frdy));
  always #50 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    addr <= a; wd <= v; wr <= 1; @(posedge clk); wr <= 0; @(posedge clk);
  endtask
  task automatic rreg(input logic [7:0] a);
    addr <= a; rd <= 1; @(posedge clk); rd <= 0; #1 d = rdat; @(posedge clk);
  endtask
  task automatic call(input logic [7:0] c);
    wreg(`TMBX_A_CALL, c); rreg(`TMBX_A_STATUS);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    n_wake += rw;
    if (cycles == 20000) begin mismatches++; conclude(); end
  end
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1; repeat (2) @(posedge clk);
    rreg(`TMBX_A_SFLAGS); `CHK(d, 8'h00)
    md <= 8'h0b;
    mwr <= 1;
    @(posedge clk);
    mwr <= 0;
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 4; i++) begin
        seed = lfsr(seed); wreg(8'h80 + 8'(i), seed[7:0]);
        exp_q.push_back({i == 3, 2'(k), seed[7:0]});
      end
      wreg(`TMBX_A_SFLAGS, 8'h01 << k);
      for (int t = 0; t < 60; t++) begin rreg(`TMBX_A_SFLAGS); if (d[k] === 1'b0) break; end
      `CHK(d[2:0], 3'b000)
    end
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed); rxd <= seed[7:0]; rxv <= 1; @(posedge clk);
      if (i == 0) b0 = seed[7:0];
    end
    rxv <= 0;
    `CHK(rxr, 1'b1)
    call(`TMBX_CALL_RX_DEQ); `CHK(d, `TMBX_RES_OK)
    rreg(`TMBX_A_PARAM1); `CHK(d, b0)
    rreg(`TMBX_A_SFLAGS); `CHK(d[3], 1'b1)
    call(`TMBX_CALL_RX_DEQ); rreg(`TMBX_A_SFLAGS); `CHK(d[3], 1'b0)
    call(`TMBX_CALL_RX_DEQ); `CHK(d, `TMBX_RES_RX_EMPTY)
    call(`TMBX_CALL_USB_INIT); wreg(`TMBX_A_COUNT, 8'h00); repeat (40) @(posedge clk);
    rreg(`TMBX_A_COUNT); `CHK(d inside {8'h04, 8'h05}, 1'b1)
    `CHK(ue, 1'b1)
    wreg(`TMBX_A_COUNT, 8'hff); repeat (12) @(posedge clk);
    rreg(`TMBX_A_CSTAT); `CHK(d, 8'h81)
    wreg(`TMBX_A_CSTAT, 8'h80); call(`TMBX_CALL_CNT_STOP);
    rreg(`TMBX_A_CSTAT); `CHK(d, 8'h00)
    // self powered, regulator off, half clock
    wreg(`TMBX_A_PARAM1, `TMBX_REG_SELF_OFF);
    wreg(`TMBX_A_PARAM1 + 8'h01, `TMBX_CLK_HALF);
    call(`TMBX_CALL_SYS_INIT);
    `CHK({d, vr, bc, ch}, {`TMBX_RES_OK, 3'b001})
    rreg(`TMBX_A_PWRCLK);
    `CHK(d, 8'h05)
    wreg(`TMBX_A_PARAM1, 8'h03);
    call(`TMBX_CALL_SYS_INIT);
    `CHK({d, vr}, {`TMBX_RES_RANGE, 1'b0})
    seed = lfsr(seed);
    for (int i = 0; i < 4; i++) wreg(`TMBX_A_PARAM1 + 8'(i), seed[8*i +: 8]);
    call(`TMBX_CALL_GPIO_INIT);
    `CHK({gl, gp}, seed)
    mwr <= 1; hdone <= 1; creq <= 1; @(posedge clk); mwr <= 0; hdone <= 0; creq <= 0;
    rreg(`TMBX_A_MODES); `CHK(d, 8'h0b)
    rreg(`TMBX_A_CFLAGS); `CHK(d[1:0], 2'b11)
    // host fills control buffer, software replies
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      hw <= 1;
      ha <= 6'(i);
      hdat <= seed[7:0];
      exp_q.push_back({i == 3, 2'h3, seed[7:0]});
      @(posedge clk);
    end
    hw <= 0;
    rreg(8'hc3);
    `CHK(d, seed[7:0])
    wreg(`TMBX_A_CFLAGS, 8'h04);
    for (int t = 0; t < 60; t++) begin
      rreg(`TMBX_A_CFLAGS);
      if (d[2] === 1'b0) break;
    end
    `CHK(d[2:0], 3'b000)
    `CHK(i_host.got.size(), 16)
    while (exp_q.size() > 0 && i_host.got.size() > 0) begin
      got_b = i_host.got.pop_front();
      exp_b = exp_q.pop_front();
      `CHK(got_b, exp_b)
    end
    call(`TMBX_CALL_REM_WAKE); `CHK(d, `TMBX_RES_WAKE_NA)
    susp <= 1; repeat (8) @(posedge clk);
    rreg(`TMBX_A_SFLAGS); `CHK(d[4], 1'b1)
    call(`TMBX_CALL_SUSP_WAKE); `CHK({xs, lw}, 2'b10)
    call(`TMBX_CALL_REM_WAKE); `CHK(d, `TMBX_RES_OK)
    susp <= 0; repeat (8) @(posedge clk);
    rreg(`TMBX_A_SFLAGS); `CHK({d[4], xs}, 2'b00)
    susp <= 1;
    repeat (8) @(posedge clk);
    call(`TMBX_CALL_SUSPEND);
    `CHK({d, lw}, {`TMBX_RES_BUSY, 1'b1})
    susp <= 0;
    repeat (8) @(posedge clk);
    rreg(`TMBX_A_STATUS);
    `CHK({d, lw}, {`TMBX_RES_OK, 1'b0})
    `CHK(n_wake, 1)
    conclude();
  end
endmodule
`default_nettype wire
